// ---- testbench/testbench.sv ----
`default_nettype none

`define CMP(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] %s expected %h seen %h", nm, e, g); end end

module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic hw_reset_n = 1'b1;
	gcr_pkg::gcr_cfg_req_t cfg_req = '0;
	logic uart2_tx_data = 1'b0;
	logic uart2_tx_busy = 1'b0;
	logic uart2_active = 1'b0;
	logic uart2_receive_pin = 1'b1;
	logic infrared_receive_pin = 1'b1;
	logic [7:0] cfg_rdata;
	logic uart2_rx_data, tx_pin, tx_oe_n, ir_pin, ir_oe_n;
	logic [3:0] ecp_fifo_level;
	logic [3:0][1:0] drive_rate_sel;
	gcr_pkg::gcr_umode_t uart_mode;
	int fail_count = 0;
	int checked = 0;
	logic [2:0] chk = 3'h0;
	logic [2:0] sel;
	logic [7:0] e, g;
	logic [7:0] exp_q[$];
	logic [7:0] mdl[3];
	logic [31:0] seed = 32'h5E;
	string nm[7] = '{"none", "rdata", "pins", "rx", "fifo", "rate", "mode"};

	gcr_global_config gcr_global_config_inst (.sys_clk(sys_clk), .rst_n(rst_n), .hw_reset_n(hw_reset_n),
		.cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .uart2_tx_data(uart2_tx_data), .uart2_tx_busy(uart2_tx_busy),
		.uart2_active(uart2_active), .uart2_rx_data(uart2_rx_data), .uart2_transmit_pin(tx_pin),
		.uart2_transmit_pin_oe_n(tx_oe_n), .infrared_transmit_pin(ir_pin), .infrared_transmit_pin_oe_n(ir_oe_n),
		.uart2_receive_pin(uart2_receive_pin), .infrared_receive_pin(infrared_receive_pin),
		.ecp_fifo_level(ecp_fifo_level), .drive_rate_sel(drive_rate_sel), .uart_mode(uart_mode));

	// Free-running 40 MHz clock
	always #12.5 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////
	// Monitor: a probe flagged before an edge is judged just after it
	always @(posedge sys_clk) begin
		if (chk != 3'h0) begin
			sel = chk;
			#1;
			case (sel)
				3'h1: g = cfg_rdata;
				3'h2: g = {4'h0, tx_pin, tx_oe_n, ir_pin, ir_oe_n};
				3'h3: g = {7'h00, uart2_rx_data};
				3'h4: g = {4'h0, ecp_fifo_level};
				3'h5: g = drive_rate_sel;
				default: g = uart_mode;
			endcase
			if (exp_q.size() == 0) begin
				`CMP("queue", 8'h01, 8'h00)
			end else begin
				e = exp_q.pop_front();
				`CMP(nm[sel], e, g)
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Drivers; inputs always move 2 ns after the rising edge
	task automatic cyc();
		@(posedge sys_clk);
		#2;
	endtask

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic acc(input logic m, input logic [7:0] i, input logic w, input logic r,
		input logic [7:0] d, input logic [7:0] ex);
		cfg_req = '{cfg_mode: m, wr: w, rd: r, index: i, wdata: d};
		if (r) begin
			exp_q.push_back(ex);
			chk = 3'h1;
		end
		cyc();
		cfg_req.wr = 1'b0;
		cfg_req.rd = 1'b0;
		chk = 3'h0;
		cyc();
	endtask

	task automatic probe(input logic [2:0] s, input logic [7:0] ex);
		exp_q.push_back(ex);
		chk = s;
		cyc();
		chk = 3'h0;
		cyc();
	endtask

	function automatic logic [7:0] rdexp(input logic [7:0] i);
		return (i >= gcr_pkg::IDX_ECP_ROUTE && i <= gcr_pkg::IDX_UART_MODE) ? mdl[i - 8'h0A] : 8'h00;
	endfunction

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Watchdog so a stuck sequence still reaches the verdict
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		conclude();
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin : main_seq
		logic [31:0] r;
		logic [7:0] i;
		logic m, v, pol;
		logic [1:0] rt;
		repeat (6) cyc();
		rst_n = 1'b1;
		mdl = '{8'h00, 8'h00, 8'h02};
		for (int k = 10; k < 13; k++) acc(1'b1, 8'(k), 1'b0, 1'b1, 8'h00, mdl[k - 10]);
		acc(1'b0, 8'h0C, 1'b0, 1'b1, 8'h00, 8'h00);
		// selectors include the reserved value too
		for (int k = 0; k < 40; k++) begin
			r = rnd();
			i = 8'h09 + 8'(r[2:0] % 5);
			m = (r[5:3] != 3'h0);
			acc(m, i, 1'b1, 1'b0, r[15:8], 8'h00);
			if (m && i >= 8'h0A && i <= 8'h0C) mdl[i - 8'h0A] = r[15:8] & ((i == 8'h0A) ? 8'hCF : 8'hFF);
			acc(1'b1, i, 1'b0, 1'b1, 8'h00, rdexp(i));
			probe(3'h4, {4'h0, mdl[0][3:0]});
			probe(3'h5, mdl[1]);
			probe(3'h6, mdl[2]);
		end
		acc(1'b1, 8'h0B, 1'b1, 1'b1, 8'h3C, mdl[1]);
		acc(1'b1, 8'h0B, 1'b0, 1'b1, 8'h00, 8'h3C);
		for (int k = 0; k < 32; k++) begin
			rt = 2'(k);
			pol = k[4];
			acc(1'b1, 8'h0A, 1'b1, 1'b0, {rt, 6'h00}, 8'h00);
			acc(1'b1, 8'h0C, 1'b1, 1'b0, {6'h00, pol, 1'b0}, 8'h00);
			uart2_active = k[2];
			uart2_tx_data = k[3];
			uart2_tx_busy = k[0];
			v = k[3] ^ pol;
			probe(3'h2, rt[1] ? 8'h05 : (!k[2] ? 8'h00 : (rt == 2'h0 ? {4'h0, v, 3'h0} : {6'h00, v, 1'b0})));
		end
		for (int k = 0; k < 32; k++) begin
			rt = 2'(k);
			v = k[2];
			pol = k[3];
			acc(1'b1, 8'h0A, 1'b1, 1'b0, {rt, 6'h00}, 8'h00);
			acc(1'b1, 8'h0C, 1'b1, 1'b0, {5'h00, k[4], 1'b0, pol}, 8'h00);
			uart2_receive_pin = (rt == 2'h1) ? ~v : v;
			infrared_receive_pin = (rt == 2'h1) ? v : ~v;
			uart2_tx_busy = k[0] ^ k[2];
			cyc();
			cyc();
			probe(3'h3, {7'h00, (rt[1] || (k[4] && (k[0] ^ k[2]))) ? 1'b1 : v ^ pol});
		end
		acc(1'b1, 8'h0A, 1'b1, 1'b0, 8'hF7, 8'h00);
		acc(1'b1, 8'h0B, 1'b1, 1'b0, 8'hA5, 8'h00);
		acc(1'b1, 8'h0C, 1'b1, 1'b0, 8'hFF, 8'h00);
		hw_reset_n = 1'b0;
		repeat (4) cyc();
		hw_reset_n = 1'b1;
		repeat (3) cyc();
		acc(1'b1, 8'h0A, 1'b0, 1'b1, 8'h00, 8'h07);
		acc(1'b1, 8'h0B, 1'b0, 1'b1, 8'h00, 8'hA5);
		acc(1'b1, 8'h0C, 1'b0, 1'b1, 8'h00, gcr_pkg::UART_MODE_RST);
		// power-on reset in mid-run clears the written values
		rst_n = 1'b0;
		repeat (6) cyc();
		rst_n = 1'b1;
		for (int k = 10; k < 13; k++) acc(1'b1, 8'(k), 1'b0, 1'b1, 8'h00, (k == 12) ? 8'h02 : 8'h00);
		repeat (3) cyc();
		conclude();
	end
endmodule

`default_nettype wire

// ---- verilog/gcr_global_config.sv ----
`default_nettype none

module gcr_global_config (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic hw_reset_n,
	input wire gcr_pkg::gcr_cfg_req_t cfg_req,
	output logic [7:0] cfg_rdata,
	input wire logic uart2_tx_data,
	input wire logic uart2_tx_busy,
	input wire logic uart2_active,
	output logic uart2_rx_data,
	output logic uart2_transmit_pin,
	output logic uart2_transmit_pin_oe_n,
	output logic infrared_transmit_pin,
	output logic infrared_transmit_pin_oe_n,
	input wire logic uart2_receive_pin,
	input wire logic infrared_receive_pin,
	output logic [3:0] ecp_fifo_level,
	output logic [3:0][1:0] drive_rate_sel,
	output gcr_pkg::gcr_umode_t uart_mode
);

	////////////////////////////////////////////////////////////////////////
	// State of the whole block
	typedef struct packed {
		gcr_pkg::gcr_ecp_t ecp;
		logic [3:0][1:0] rate;
		gcr_pkg::gcr_umode_t umode;
		logic [7:0] rdata;
		gcr_pkg::gcr_pins_t pins;
		logic rx;
		logic hwr_meta;
		logic hwr_sync;
		logic std_rx_meta;
		logic std_rx_sync;
		logic ir_rx_meta;
		logic ir_rx_sync;
	} gcr_state_t;

	localparam gcr_state_t ST_RST = '{
		// Reserved bits 5:4 are never stored, so only route and threshold take a reset value
		ecp: gcr_pkg::gcr_ecp_t'({gcr_pkg::ECP_ROUTE_RST[gcr_pkg::ROUTE_MSB:gcr_pkg::ROUTE_LSB],
			gcr_pkg::ECP_ROUTE_RST[gcr_pkg::FIFO_MSB:gcr_pkg::FIFO_LSB]}),
		rate: gcr_pkg::DRIVE_RATE_RST,
		umode: gcr_pkg::gcr_umode_t'(gcr_pkg::UART_MODE_RST),
		rdata: gcr_pkg::RD_UNMAPPED,
		pins: 4'h0,
		rx: gcr_pkg::RX_IDLE,
		hwr_meta: 1'h0,
		hwr_sync: 1'h0,
		std_rx_meta: 1'h1,
		std_rx_sync: 1'h1,
		ir_rx_meta: 1'h1,
		ir_rx_sync: 1'h1
	};

	gcr_state_t st_ff;
	gcr_state_t nxt_st;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// True when the request targets the given index in configuration state
	function automatic logic cfg_hit(input gcr_pkg::gcr_cfg_req_t req, input logic [7:0] idx);
		cfg_hit = req.cfg_mode && (req.index == idx);
	endfunction

	// Read image of the first register; reserved bits are never stored
	function automatic logic [7:0] ecp_image(input gcr_pkg::gcr_ecp_t e);
		ecp_image = {e.route, gcr_pkg::RSVD_READ, e.fifo_level};
	endfunction

	// Line level after polarity; the core always sees an active-high line
	function automatic logic apply_pol(input logic line, input logic active_low);
		apply_pol = line ^ active_low;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		logic wr_ecp;
		logic wr_rate;
		logic wr_mode;
		logic tx_line;
		logic rx_line;
		wr_ecp = 1'h0;
		wr_rate = 1'h0;
		wr_mode = 1'h0;
		tx_line = 1'h0;
		rx_line = gcr_pkg::RX_IDLE;
		nxt_st = st_ff;

		// Two-flop synchronisers for the reset pin and receive pins
		nxt_st.hwr_meta = ~hw_reset_n;
		nxt_st.hwr_sync = st_ff.hwr_meta;
		nxt_st.std_rx_meta = uart2_receive_pin;
		nxt_st.std_rx_sync = st_ff.std_rx_meta;
		nxt_st.ir_rx_meta = infrared_receive_pin;
		nxt_st.ir_rx_sync = st_ff.ir_rx_meta;

		wr_ecp = cfg_req.wr && cfg_hit(cfg_req, gcr_pkg::IDX_ECP_ROUTE);
		wr_rate = cfg_req.wr && cfg_hit(cfg_req, gcr_pkg::IDX_DRIVE_RATE);
		wr_mode = cfg_req.wr && cfg_hit(cfg_req, gcr_pkg::IDX_UART_MODE);

		if (wr_ecp) begin
			nxt_st.ecp.fifo_level = cfg_req.wdata[gcr_pkg::FIFO_MSB:gcr_pkg::FIFO_LSB];
			nxt_st.ecp.route = gcr_pkg::gcr_route_t'(cfg_req.wdata[gcr_pkg::ROUTE_MSB:gcr_pkg::ROUTE_LSB]);
		end

		// value 11 stored as written; software is expected to avoid it
		if (wr_rate) begin
			nxt_st.rate = cfg_req.wdata;
		end

		// mode bits stored as written; reserved codes act as standard
		// speed enables taken straight from the byte
		if (wr_mode) begin
			nxt_st.umode = gcr_pkg::gcr_umode_t'(cfg_req.wdata);
		end

		// hardware reset clears the route, not the threshold or drive rate
		// hardware reset restores the mode register
		// Hardware reset outranks a write in the same cycle
		if (st_ff.hwr_sync) begin
			nxt_st.ecp.route = gcr_pkg::ROUTE_COM;
			nxt_st.umode = gcr_pkg::gcr_umode_t'(gcr_pkg::UART_MODE_RST);
		end

		// Read data is latched on the read strobe and held until the next one
		if (cfg_req.rd) begin
			if (cfg_hit(cfg_req, gcr_pkg::IDX_ECP_ROUTE)) begin
				nxt_st.rdata = ecp_image(st_ff.ecp);
			end else if (cfg_hit(cfg_req, gcr_pkg::IDX_DRIVE_RATE)) begin
				nxt_st.rdata = st_ff.rate;
			end else if (cfg_hit(cfg_req, gcr_pkg::IDX_UART_MODE)) begin
				nxt_st.rdata = st_ff.umode;
			end else begin
				nxt_st.rdata = gcr_pkg::RD_UNMAPPED;
			end
		end

		tx_line = apply_pol(uart2_tx_data, st_ff.umode.tx_active_low);

		// Pin routing; outputs are registered so the pins never glitch
		case (st_ff.ecp.route)
			gcr_pkg::ROUTE_COM: begin
				nxt_st.pins.std_oe_n = 1'h0;
				nxt_st.pins.ir_oe_n = 1'h0;
				nxt_st.pins.std_tx = uart2_active ? tx_line : 1'h0;
				nxt_st.pins.ir_tx = 1'h0;
			end
			gcr_pkg::ROUTE_IR: begin
				nxt_st.pins.std_oe_n = 1'h0;
				nxt_st.pins.ir_oe_n = 1'h0;
				nxt_st.pins.std_tx = 1'h0;
				nxt_st.pins.ir_tx = uart2_active ? tx_line : 1'h0;
			end
			// both floated; reserved code floats too so nothing is driven blindly
			default: begin
				nxt_st.pins.std_oe_n = 1'h1;
				nxt_st.pins.ir_oe_n = 1'h1;
				nxt_st.pins.std_tx = 1'h0;
				nxt_st.pins.ir_tx = 1'h0;
			end
		endcase

		// Receive source follows the same route as transmit
		case (st_ff.ecp.route)
			gcr_pkg::ROUTE_COM: rx_line = st_ff.std_rx_sync;
			gcr_pkg::ROUTE_IR: rx_line = st_ff.ir_rx_sync;
			default: rx_line = gcr_pkg::RX_IDLE ^ st_ff.umode.rx_active_low;
		endcase

		// half duplex blinds the receiver while transmitting to drop echo
		if (st_ff.umode.half_duplex && uart2_tx_busy) begin
			nxt_st.rx = gcr_pkg::RX_IDLE;
		end else begin
			nxt_st.rx = apply_pol(rx_line, st_ff.umode.rx_active_low);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register; rst_n is the power-on reset
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_ff <= ST_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from flip-flops
	assign cfg_rdata = st_ff.rdata;
	assign uart2_rx_data = st_ff.rx;
	assign uart2_transmit_pin = st_ff.pins.std_tx;
	assign uart2_transmit_pin_oe_n = st_ff.pins.std_oe_n;
	assign infrared_transmit_pin = st_ff.pins.ir_tx;
	assign infrared_transmit_pin_oe_n = st_ff.pins.ir_oe_n;
	assign ecp_fifo_level = st_ff.ecp.fifo_level;
	assign drive_rate_sel = st_ff.rate;
	assign uart_mode = st_ff.umode;

	////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	// Write strobes that really reach a register; same decode as the next-state logic
	logic wr_ecp_hit;
	logic wr_rate_hit;
	logic wr_mode_hit;
	logic rd_ecp_hit;
	logic rd_rate_hit;
	logic rd_mode_hit;
	logic rd_miss;
	assign wr_ecp_hit = cfg_req.wr && cfg_hit(cfg_req, gcr_pkg::IDX_ECP_ROUTE);
	assign wr_rate_hit = cfg_req.wr && cfg_hit(cfg_req, gcr_pkg::IDX_DRIVE_RATE);
	assign wr_mode_hit = cfg_req.wr && cfg_hit(cfg_req, gcr_pkg::IDX_UART_MODE);
	// Read strobes split by target; a miss must answer the unmapped value
	assign rd_ecp_hit = cfg_req.rd && cfg_hit(cfg_req, gcr_pkg::IDX_ECP_ROUTE);
	assign rd_rate_hit = cfg_req.rd && cfg_hit(cfg_req, gcr_pkg::IDX_DRIVE_RATE);
	assign rd_mode_hit = cfg_req.rd && cfg_hit(cfg_req, gcr_pkg::IDX_UART_MODE);
	assign rd_miss = cfg_req.rd && !rd_ecp_hit && !rd_rate_hit && !rd_mode_hit;

	ecp_write_a: assert property (wr_ecp_hit && !st_ff.hwr_sync |=>
		ecp_fifo_level == $past(cfg_req.wdata[gcr_pkg::FIFO_MSB:gcr_pkg::FIFO_LSB])
		&& st_ff.ecp.route == $past(cfg_req.wdata[gcr_pkg::ROUTE_MSB:gcr_pkg::ROUTE_LSB]))
		else $error("first register write not stored");

	rsvd_read_a: assert property (rd_ecp_hit |=>
		cfg_rdata[5:4] == gcr_pkg::RSVD_READ && cfg_rdata[3:0] == $past(ecp_fifo_level))
		else $error("reserved bits read nonzero");

	ecp_read_a: assert property (rd_ecp_hit |=>
		cfg_rdata[7:6] == $past(st_ff.ecp.route))
		else $error("first register read image wrong");

	rate_read_a: assert property (rd_rate_hit |=> cfg_rdata == $past(drive_rate_sel))
		else $error("drive-rate read image wrong");

	mode_read_a: assert property (rd_mode_hit |=> cfg_rdata == $past(uart_mode))
		else $error("mode read image wrong");

	miss_read_a: assert property (rd_miss |=> cfg_rdata == gcr_pkg::RD_UNMAPPED)
		else $error("unmapped read not zero");

	hw_reset_a: assert property (!hw_reset_n ##1 !hw_reset_n ##1 !hw_reset_n |=>
		st_ff.ecp.route == gcr_pkg::ROUTE_COM && uart_mode == gcr_pkg::UART_MODE_RST)
		else $error("hardware reset did not restore route and mode");

	hw_keep_a: assert property (st_ff.hwr_sync && !wr_ecp_hit && !wr_rate_hit |=>
		$stable(ecp_fifo_level) && $stable(drive_rate_sel))
		else $error("hardware reset disturbed threshold or drive rate");

	mode_reset_a: assert property (st_ff.hwr_sync |=> uart_mode == gcr_pkg::UART_MODE_RST)
		else $error("mode register not 0x02 after hardware reset");

	mode_write_a: assert property (wr_mode_hit && !st_ff.hwr_sync |=>
		uart_mode == $past(cfg_req.wdata))
		else $error("mode write not stored");

	com_idle_a: assert property (st_ff.ecp.route == gcr_pkg::ROUTE_COM && !uart2_active |=>
		!uart2_transmit_pin && !infrared_transmit_pin && !uart2_transmit_pin_oe_n && !infrared_transmit_pin_oe_n)
		else $error("COM route powered down but transmit pins not low");

	com_route_a: assert property (st_ff.ecp.route == gcr_pkg::ROUTE_COM |=>
		!infrared_transmit_pin && !uart2_transmit_pin_oe_n
		&& uart2_transmit_pin == ($past(uart2_active) & ($past(uart2_tx_data) ^ $past(uart_mode.tx_active_low))))
		else $error("COM route output wrong");

	ir_route_a: assert property (st_ff.ecp.route == gcr_pkg::ROUTE_IR |=>
		!uart2_transmit_pin && !infrared_transmit_pin_oe_n
		&& infrared_transmit_pin == ($past(uart2_active) & ($past(uart2_tx_data) ^ $past(uart_mode.tx_active_low))))
		else $error("infrared route output wrong");

	ir_idle_a: assert property (st_ff.ecp.route == gcr_pkg::ROUTE_IR && !uart2_active |=>
		!uart2_transmit_pin && !infrared_transmit_pin && !uart2_transmit_pin_oe_n && !infrared_transmit_pin_oe_n)
		else $error("infrared route powered down but transmit pins not low");

	pins_float_a: assert property (st_ff.ecp.route == gcr_pkg::ROUTE_OFF |=>
		uart2_transmit_pin_oe_n && infrared_transmit_pin_oe_n)
		else $error("transmit pins driven in floating route");

	rsvd_float_a: assert property (st_ff.ecp.route[1] |=>
		uart2_transmit_pin_oe_n && infrared_transmit_pin_oe_n && !uart2_transmit_pin && !infrared_transmit_pin)
		else $error("transmit pins driven or not parked in floated route");

	rate_write_a: assert property (wr_rate_hit |=> drive_rate_sel == $past(cfg_req.wdata))
		else $error("drive-rate write not stored");

	rx_pol_a: assert property (st_ff.ecp.route == gcr_pkg::ROUTE_COM && !uart_mode.half_duplex |=>
		uart2_rx_data == ($past(st_ff.std_rx_sync) ^ $past(uart_mode.rx_active_low)))
		else $error("receive polarity wrong");

	ir_rx_a: assert property (st_ff.ecp.route == gcr_pkg::ROUTE_IR && !uart_mode.half_duplex |=>
		uart2_rx_data == ($past(st_ff.ir_rx_sync) ^ $past(uart_mode.rx_active_low)))
		else $error("infrared receive path wrong");

	rx_idle_a: assert property (st_ff.ecp.route[1] |=> uart2_rx_data == gcr_pkg::RX_IDLE)
		else $error("receiver not idle in floated route");

	half_dup_a: assert property (uart_mode.half_duplex && uart2_tx_busy |=> uart2_rx_data == gcr_pkg::RX_IDLE)
		else $error("receiver not blinded in half duplex");

	locked_a: assert property (!wr_ecp_hit && !wr_rate_hit && !wr_mode_hit && !st_ff.hwr_sync |=>
		$stable(st_ff.ecp) && $stable(drive_rate_sel) && $stable(uart_mode))
		else $error("register changed without a matching write");

	////////////////////////////////////////////////////////////////////////
	// Scenario covers; the hardware reset one allows for the synchroniser delay
	ir_route_c: cover property (wr_ecp_hit && cfg_req.wdata[7:6] == 2'h1 ##2 infrared_transmit_pin);
	float_c: cover property (st_ff.ecp.route == gcr_pkg::ROUTE_OFF ##1 uart2_transmit_pin_oe_n);
	hw_reset_c: cover property (wr_mode_hit ##[1:4] st_ff.hwr_sync ##1 uart_mode == gcr_pkg::UART_MODE_RST);
	rx_blind_c: cover property (uart_mode.half_duplex && uart2_tx_busy ##1 uart2_rx_data);
	miss_read_c: cover property (rd_miss && !cfg_req.cfg_mode);

endmodule

`default_nettype wire

// ---- verilog/gcr_pkg.sv ----
`default_nettype none

package gcr_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register indexes and reset values
	localparam logic [7:0] IDX_ECP_ROUTE = 8'h0A;
	localparam logic [7:0] IDX_DRIVE_RATE = 8'h0B;
	localparam logic [7:0] IDX_UART_MODE = 8'h0C;
	localparam logic [7:0] ECP_ROUTE_RST = 8'h00;
	localparam logic [7:0] DRIVE_RATE_RST = 8'h00;
	localparam logic [7:0] UART_MODE_RST = 8'h02;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Field positions in the first register
	localparam int FIFO_LSB = 0;
	localparam int FIFO_MSB = 3;
	localparam int ROUTE_LSB = 6;
	localparam int ROUTE_MSB = 7;
	localparam logic [1:0] RSVD_READ = 2'h0;

	// Idle level of the receive line seen by the UART core
	localparam logic RX_IDLE = 1'h1;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {
		ROUTE_COM = 2'h0,
		ROUTE_IR = 2'h1,
		ROUTE_RSVD = 2'h2,
		ROUTE_OFF = 2'h3
	} gcr_route_t;

	typedef enum logic [2:0] {
		MODE_STD = 3'h0,
		MODE_SIR = 3'h1,
		MODE_ASK = 3'h2
	} gcr_uart_mode_t;

	typedef struct packed {
		logic uart2_fast;
		logic uart1_fast;
		logic [2:0] uart2_mode;
		logic half_duplex;
		logic tx_active_low;
		logic rx_active_low;
	} gcr_umode_t;

	typedef struct packed {
		gcr_route_t route;
		logic [3:0] fifo_level;
	} gcr_ecp_t;

	typedef struct packed {
		logic cfg_mode;
		logic wr;
		logic rd;
		logic [7:0] index;
		logic [7:0] wdata;
	} gcr_cfg_req_t;

	typedef struct packed {
		logic std_tx;
		logic std_oe_n;
		logic ir_tx;
		logic ir_oe_n;
	} gcr_pins_t;

endpackage

`default_nettype wire
